//--- rtl/psw_pkg.sv
// Package: field layout of the sublayer header and segment table entries, beat kinds,
// channel kinds and sizes shared by both ends.
// Assumes both ends run on one packet clock with a synchronous active-high reset.
package psw_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Header word layout.
  localparam int VCCV_BIT  = 31;
  localparam int SEQV_BIT  = 30;
  localparam int FLOW_LSB  = 25;
  localparam int COUNT_LSB = 16;
  localparam int SEQ_LSB   = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Segment table entry layout, most significant bit first.
  localparam int BEGIN_BIT = 31;
  localparam int END_BIT   = 30;
  localparam int LEN_LSB   = 16;
  localparam int CHAN_LSB  = 8;
  localparam int CSEQ_LSB  = 4;
  localparam int PROF_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes, reset values and checksum constants.
  localparam int          MAX_ENTRIES = 127;
  localparam int          FLOWS       = 8;
  localparam int          CHANS       = 256;
  localparam logic [13:0] CRC_BYTES   = 14'h0003;
  localparam logic [13:0] TS_BYTES    = 14'h0004;
  localparam logic [23:0] CRC_POLY    = 24'h80_0063;
  localparam logic [23:0] CRC_INIT    = 24'hFF_FFFF;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;

  ////////////////////////////////////////////////////////////////////////////////
  // Beat and channel kinds.
  typedef enum logic [1:0] {
    BEAT_HDR     = 2'h0,
    BEAT_ENTRY   = 2'h1,
    BEAT_PAYLOAD = 2'h3
  } beat_t;

  typedef enum logic [1:0] {
    CH_SINGLE = 2'h0,
    CH_OFDM   = 2'h1,
    CH_LINK   = 2'h3
  } chan_kind_t;

endpackage

//--- rtl/psw_link_if.sv
// Interface: the word stream from the headend end to the remote node end.
// Assumes both ends share the packet clock; the bench connects the two modports.
interface psw_link_if;
  logic              valid;
  logic              ready;
  psw_pkg::beat_t    kind;
  logic [31:0]       data;

  modport headend (output valid, output kind, output data, input ready);
  modport remote  (input valid, input kind, input data, output ready);
endinterface

//--- rtl/psw_headend_end.sv
// Headend end: builds header words, segment table entries and payload beats.
// Assumes the user gives one header, then entry_count entries, then the payload bytes.
module psw_headend_end (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // User request
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire psw_pkg::beat_t       in_kind,
  input  wire logic [2:0]           in_flow,
  input  wire logic [6:0]           in_count,
  input  wire logic                 in_begin,
  input  wire logic                 in_end,
  input  wire logic [13:0]          in_len,
  input  wire logic [7:0]           in_chan,
  input  wire psw_pkg::chan_kind_t  in_chan_kind,
  input  wire logic [3:0]           in_profile,
  input  wire logic                 in_seg_type,
  input  wire logic [7:0]           in_byte,
  // Link
  psw_link_if.headend               link
);

  typedef struct packed {
    logic                       rdy;
    logic                       valid;
    psw_pkg::beat_t             kind;
    logic [31:0]                data;
    logic [2:0]                 flow;
    logic [7:0]                 used;
    logic [15:0]                lfsr;
    logic [7:0][15:0]           pkt;
    logic [2047:0][3:0]         cseq;
  } hstate_t;

  hstate_t s;
  hstate_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic [10:0] ci;
    logic [15:0] seq;
    logic [3:0]  prof;
    logic        msg;
    ci   = 11'h000;
    seq  = 16'h0000;
    prof = 4'h0;
    msg  = 1'b0;
    next_s = s;
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    if (link.ready) begin
      next_s.valid = 1'b0;
    end
    if (in_valid && s.rdy) begin
      next_s.valid = 1'b1;
      next_s.kind  = in_kind;
      unique case (in_kind)
        psw_pkg::BEAT_HDR: begin
          next_s.flow = in_flow;
          seq = s.used[in_flow] ? s.pkt[in_flow] : s.lfsr;
          next_s.pkt[in_flow]  = seq + 16'h0001;
          next_s.used[in_flow] = 1'b1;
          next_s.data = {1'b0, 1'b1, 2'h0, in_flow, 2'h0, in_count, seq};
        end
        psw_pkg::BEAT_ENTRY: begin
          ci  = {s.flow, in_chan};
          msg = (in_chan_kind == psw_pkg::CH_LINK) && in_seg_type;
          unique case (in_chan_kind)
            psw_pkg::CH_SINGLE: prof = 4'h0;
            psw_pkg::CH_OFDM:  prof = in_begin ? in_profile : 4'h0;
            psw_pkg::CH_LINK:  prof = {3'h0, in_seg_type};
            default:           prof = 4'h0;
          endcase
          next_s.cseq[ci] = s.cseq[ci] + 4'h1;
          next_s.data = {in_begin, in_end & ~msg, in_len, in_chan,
                         s.cseq[ci], prof};
        end
        default: begin
          next_s.data = {24'h00_0000, in_byte};
        end
      endcase
    end
    next_s.rdy = !next_s.valid;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      s      <= '0;
      s.rdy  <= 1'b1;
      s.lfsr <= psw_pkg::LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready   = s.rdy;
  assign link.valid = s.valid;
  assign link.kind  = s.kind;
  assign link.data  = s.data;

endmodule

//--- rtl/psw_remote_end.sv
// Remote node end: buffers link words, decodes headers and entries, checks both
// sequence counters, and fills the checksum of message blocks in the payload.
// Assumes the headend end sends header, entries, then payload, in that order.
module psw_remote_end (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Channel map
  input  wire logic [7:0]           ofdm_tag,
  input  wire logic [7:0]           link_tag,
  // Link
  psw_link_if.remote                link,
  // Decoded stream
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output psw_pkg::beat_t            out_kind,
  output logic [2:0]                out_flow,
  output logic [6:0]                out_seg,
  output logic                      out_begin,
  output logic                      out_end,
  output logic [13:0]               out_len,
  output logic [7:0]                out_chan,
  output psw_pkg::chan_kind_t       out_chan_kind,
  output logic [3:0]                out_profile,
  output logic                      out_msg,
  output logic                      out_stamp,
  output logic [7:0]                out_byte,
  // Loss events
  output logic                      pkt_loss,
  output logic                      seg_loss
);

  typedef struct packed {
    logic [1:0][33:0]           fmem;
    logic                       frd;
    logic [1:0]                 fcnt;
    logic                       room;
    logic                       ov;
    psw_pkg::beat_t             okind;
    logic [2:0]                 oflow;
    logic [6:0]                 oseg;
    logic                       obegin;
    logic                       oend;
    logic [13:0]                olen;
    logic [7:0]                 ochan;
    psw_pkg::chan_kind_t        ock;
    logic [3:0]                 oprof;
    logic                       omsg;
    logic                       ostamp;
    logic [7:0]                 obyte;
    logic                       pkt_loss;
    logic                       seg_loss;
    logic [2:0]                 flow;
    logic [6:0]                 ecount;
    logic [6:0]                 eidx;
    logic [6:0]                 pidx;
    logic [13:0]                pos;
    logic [23:0]                crc;
    logic [126:0][13:0]         tlen;
    logic [126:0]               tmsg;
    logic [126:0]               tts;
    logic [7:0][15:0]           sexp;
    logic [7:0]                 sseen;
    logic [2047:0][3:0]         cexp;
    logic [2047:0]              cseen;
  } rstate_t;

  rstate_t s;
  rstate_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // One checksum step over a byte, most significant bit first.
  function automatic logic [23:0] crc_step(input logic [23:0] c, input logic [7:0] b);
    logic [23:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[23] ^ b[i]) begin
        r = {r[22:0], 1'b0} ^ psw_pkg::CRC_POLY;
      end else begin
        r = {r[22:0], 1'b0};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic                push;
    logic                pop;
    logic [33:0]         head;
    logic [31:0]         d;
    logic [2:0]          f;
    logic [10:0]         ci;
    psw_pkg::chan_kind_t ck;
    logic                msg;
    logic                ts;
    logic                in_ts;
    logic [13:0]         len;
    logic [13:0]         p;
    logic [13:0]         cstart;
    logic [13:0]         k;
    logic [23:0]         c;
    push   = 1'b0;
    pop    = 1'b0;
    head   = s.fmem[s.frd];
    d      = head[31:0];
    f      = 3'h0;
    ci     = 11'h000;
    ck     = psw_pkg::CH_SINGLE;
    msg    = 1'b0;
    ts     = 1'b0;
    in_ts  = 1'b0;
    len    = 14'h0000;
    p      = 14'h0000;
    cstart = 14'h0000;
    k      = 14'h0000;
    c      = 24'h00_0000;
    next_s = s;
    next_s.pkt_loss = 1'b0;
    next_s.seg_loss = 1'b0;
    if (out_ready) begin
      next_s.ov = 1'b0;
    end
    push = link.valid && s.room;
    pop  = (s.fcnt != 2'h0) && (!s.ov || out_ready);
    if (push) begin
      next_s.fmem[s.frd ^ s.fcnt[0]] = {link.kind, link.data};
    end
    if (pop) begin
      next_s.frd = ~s.frd;
      unique case (psw_pkg::beat_t'(head[33:32]))
        psw_pkg::BEAT_HDR: begin
          f = d[psw_pkg::FLOW_LSB +: 3];
          next_s.flow   = f;
          next_s.ecount = d[psw_pkg::COUNT_LSB +: 7];
          next_s.eidx   = 7'h00;
          next_s.pidx   = 7'h00;
          next_s.pos    = 14'h0000;
          if (s.sseen[f] && (d[psw_pkg::SEQ_LSB +: 16] != s.sexp[f])) begin
            next_s.pkt_loss = 1'b1;
          end
          next_s.sexp[f]  = d[psw_pkg::SEQ_LSB +: 16] + 16'h0001;
          next_s.sseen[f] = 1'b1;
        end
        psw_pkg::BEAT_ENTRY: begin
          if (s.eidx < s.ecount) begin
            ci = {s.flow, d[psw_pkg::CHAN_LSB +: 8]};
            if (d[psw_pkg::CHAN_LSB +: 8] == link_tag) begin
              ck = psw_pkg::CH_LINK;
            end else if (d[psw_pkg::CHAN_LSB +: 8] == ofdm_tag) begin
              ck = psw_pkg::CH_OFDM;
            end
            msg = (ck == psw_pkg::CH_LINK) && d[psw_pkg::PROF_LSB];
            ts  = msg && d[psw_pkg::BEGIN_BIT];
            if (s.cseen[ci] && (d[psw_pkg::CSEQ_LSB +: 4] != s.cexp[ci])) begin
              next_s.seg_loss = 1'b1;
            end
            next_s.cexp[ci]  = d[psw_pkg::CSEQ_LSB +: 4] + 4'h1;
            next_s.cseen[ci] = 1'b1;
            next_s.tlen[s.eidx] = d[psw_pkg::LEN_LSB +: 14];
            next_s.tmsg[s.eidx] = msg;
            next_s.tts[s.eidx]  = ts;
            next_s.eidx   = s.eidx + 7'h01;
            next_s.ov     = 1'b1;
            next_s.okind  = psw_pkg::BEAT_ENTRY;
            next_s.oflow  = s.flow;
            next_s.oseg   = s.eidx;
            next_s.obegin = d[psw_pkg::BEGIN_BIT];
            next_s.oend   = d[psw_pkg::END_BIT] & ~msg;
            next_s.olen   = d[psw_pkg::LEN_LSB +: 14];
            next_s.ochan  = d[psw_pkg::CHAN_LSB +: 8];
            next_s.ock    = ck;
            next_s.omsg   = msg;
            next_s.ostamp = ts;
            unique case (ck)
              psw_pkg::CH_SINGLE: next_s.oprof = 4'h0;
              psw_pkg::CH_OFDM: begin
                next_s.oprof = d[psw_pkg::BEGIN_BIT] ? d[psw_pkg::PROF_LSB +: 4]
                                                     : 4'h0;
              end
              default: next_s.oprof = {3'h0, d[psw_pkg::PROF_LSB]};
            endcase
          end
        end
        default: begin
          if (s.pidx < s.eidx) begin
            len    = s.tlen[s.pidx];
            msg    = s.tmsg[s.pidx];
            ts     = s.tts[s.pidx];
            p      = s.pos;
            cstart = len - psw_pkg::CRC_BYTES;
            in_ts  = ts && (p < psw_pkg::TS_BYTES);
            c      = (p == 14'h0000) ? psw_pkg::CRC_INIT : s.crc;
            next_s.obyte = d[7:0];
            if (msg && (p >= cstart)) begin
              k = p - cstart;
              if (k[1:0] == 2'h0) begin
                next_s.obyte = c[23:16];
              end else if (k[1:0] == 2'h1) begin
                next_s.obyte = c[15:8];
              end else begin
                next_s.obyte = c[7:0];
              end
            end else if (msg && !in_ts) begin
              c = crc_step(c, d[7:0]);
            end
            next_s.crc    = c;
            next_s.ov     = 1'b1;
            next_s.okind  = psw_pkg::BEAT_PAYLOAD;
            next_s.oflow  = s.flow;
            next_s.oseg   = s.pidx;
            next_s.olen   = len;
            next_s.omsg   = msg;
            next_s.ostamp = in_ts;
            if (p + 14'h0001 >= len) begin
              next_s.pidx = s.pidx + 7'h01;
              next_s.pos  = 14'h0000;
            end else begin
              next_s.pos  = p + 14'h0001;
            end
          end
        end
      endcase
    end
    next_s.fcnt = s.fcnt + {1'b0, push} - {1'b0, pop};
    next_s.room = (next_s.fcnt != 2'h2);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      s      <= '0;
      s.room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.ready    = s.room;
  assign out_valid     = s.ov;
  assign out_kind      = s.okind;
  assign out_flow      = s.oflow;
  assign out_seg       = s.oseg;
  assign out_begin     = s.obegin;
  assign out_end       = s.oend;
  assign out_len       = s.olen;
  assign out_chan      = s.ochan;
  assign out_chan_kind = s.ock;
  assign out_profile   = s.oprof;
  assign out_msg       = s.omsg;
  assign out_stamp     = s.ostamp;
  assign out_byte      = s.obyte;
  assign pkt_loss      = s.pkt_loss;
  assign seg_loss      = s.seg_loss;

endmodule

//--- testbench/psw_link_props.sv
// Checker: concurrent assertions on the link words between the two ends.
// Assumes the bench feeds it the link signals and the packet clock and reset.
module psw_link_props (
  // Clock and reset
  input wire logic           clk,
  input wire logic           reset,
  // Link
  input wire logic           valid,
  input wire logic           ready,
  input wire psw_pkg::beat_t kind,
  input wire logic [31:0]    data
);
  logic        take;
  logic [2:0]  flow;
  logic [6:0]  rem;
  logic [7:0]  seen;
  logic [15:0] last_seq [8];
  logic [3:0]  cseq [2048];

  assign take = valid && ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Tracks entries still owed, the current flow and both sequence counters.
  always_ff @(posedge clk) begin
    if (reset) begin
      rem <= 7'h0;
      seen <= 8'h0;
      flow <= 3'h0;
      for (int i = 0; i < 2048; i++) cseq[i] <= 4'h0;
    end else if (take && kind == psw_pkg::BEAT_HDR) begin
      rem <= data[22:16];
      flow <= data[27:25];
      seen[data[27:25]] <= 1'b1;
      last_seq[data[27:25]] <= data[15:0];
    end else if (take && kind == psw_pkg::BEAT_ENTRY) begin
      rem <= rem - 7'h1;
      cseq[{flow, data[15:8]}] <= data[7:4] + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hdr_fixed_bits: assert property (valid && kind == psw_pkg::BEAT_HDR |->
    data[31:28] == 4'h4 && data[24:23] == 2'h0) else $error("header fixed bits wrong");
  a_word_holds: assert property (valid && !ready |=>
    valid && $stable(data) && $stable(kind)) else $error("link word changed while held");
  a_payload_clean: assert property (valid && kind == psw_pkg::BEAT_PAYLOAD |->
    data[31:8] == 24'h0) else $error("payload word upper bits set");
  a_profile_upper: assert property (
    valid && kind == psw_pkg::BEAT_ENTRY && !data[31] |->
    data[3:1] == 3'h0) else $error("profile upper bits set without begin");
  a_entry_in_count: assert property (valid && kind == psw_pkg::BEAT_ENTRY |->
    rem != 7'h0) else $error("more entries than the header count");
  a_entries_done: assert property (valid && kind != psw_pkg::BEAT_ENTRY |->
    rem == 7'h0) else $error("entry missing before next word");
  a_pkt_seq_step: assert property (
    valid && kind == psw_pkg::BEAT_HDR && seen[data[27:25]] |->
    data[15:0] == last_seq[data[27:25]] + 16'h1) else $error("packet counter step wrong");
  a_chan_seq_step: assert property (valid && kind == psw_pkg::BEAT_ENTRY |->
    data[7:4] == cseq[{flow, data[15:8]}]) else $error("channel counter step wrong");
endmodule

//--- testbench/pseudowire_segment_table_codec_bench.sv
// Bench: headend end and remote end joined by the link, plus a remote end fed raw words.
// Assumes the package, the interface and both ends are compiled first.
module pseudowire_segment_table_codec_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    psw_pkg::chan_kind_t ck;
    logic [7:0]          chan;
    logic                b;
    logic                e;
    logic                t;
    logic [3:0]          prof;
    logic [13:0]         len;
  } seg_t;

  logic                clk, reset, in_valid, in_ready, in_begin, in_end, in_seg_type;
  logic                out_valid, out_ready, out_begin, out_end, out_msg, out_stamp;
  logic                pkt_loss, seg_loss, f_pkt, f_seg;
  logic [2:0]          in_flow, out_flow, fl;
  logic [6:0]          in_count, out_seg;
  logic [13:0]         in_len, out_len;
  logic [7:0]          in_chan, in_byte, out_chan, out_byte, ofdm_tag, link_tag;
  logic [7:0]          n_fpkt, n_fseg, n_main;
  logic [3:0]          in_profile, out_profile;
  psw_pkg::beat_t      in_kind, out_kind;
  psw_pkg::chan_kind_t in_chan_kind, out_chan_kind;
  logic [43:0]         notes [$];
  int                  n_fail, samples_checked, seg_no;

  psw_link_if lk ();
  psw_link_if lf ();

  psw_headend_end psw_headend_end_i (.clk, .reset, .in_valid, .in_ready, .in_kind, .in_flow,
    .in_count, .in_begin, .in_end, .in_len, .in_chan, .in_chan_kind, .in_profile,
    .in_seg_type, .in_byte, .link(lk));
  psw_remote_end psw_remote_end_i (.clk, .reset, .ofdm_tag, .link_tag, .link(lk), .out_valid,
    .out_ready, .out_kind, .out_flow, .out_seg, .out_begin, .out_end, .out_len, .out_chan,
    .out_chan_kind, .out_profile, .out_msg, .out_stamp, .out_byte, .pkt_loss, .seg_loss);
  psw_remote_end psw_remote_end_fault_i (.clk, .reset, .ofdm_tag, .link_tag, .link(lf),
    .out_valid(), .out_ready(1'b1), .out_kind(), .out_flow(), .out_seg(), .out_begin(),
    .out_end(), .out_len(), .out_chan(), .out_chan_kind(), .out_profile(), .out_msg(),
    .out_stamp(), .out_byte(), .pkt_loss(f_pkt), .seg_loss(f_seg));
  psw_link_props psw_link_props_i (.clk, .reset, .valid(lk.valid), .ready(lk.ready),
    .kind(lk.kind), .data(lk.data));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, compare tasks and the end of the run.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check_beat(input logic [43:0] exp, input logic [43:0] act);
    samples_checked++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR %0t exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic check_flag(input logic [7:0] exp, input logic [7:0] act);
    samples_checked++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR %0t exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expected values and drivers.
  function automatic logic [23:0] crc_step(logic [23:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[22:0], 1'b0} ^ (c[23] ^ b[i] ? psw_pkg::CRC_POLY : 24'h0);
    return c;
  endfunction

  function automatic logic [43:0] note(psw_pkg::beat_t k, logic [6:0] i, seg_t s, logic st,
                                       logic [7:0] by);
    logic       m;
    logic [3:0] p;
    m = s.ck == psw_pkg::CH_LINK && s.t;
    p = s.ck == psw_pkg::CH_LINK ? {3'h0, s.t} : (s.ck == psw_pkg::CH_OFDM && s.b ? s.prof : 4'h0);
    if (k == psw_pkg::BEAT_ENTRY)
      return {k, fl, i, s.len, m, m && s.b, s.b, s.e && !m, s.ck, p, s.chan};
    return {k, fl, i, s.len, m, st, 8'h0, by};
  endfunction

  task automatic beat(input psw_pkg::beat_t k, input seg_t s, input logic [6:0] n,
                      input logic [7:0] by);
    @(posedge clk);
    in_valid <= 1'b1;
    in_kind <= k;
    in_flow <= fl;
    in_count <= n;
    in_byte <= by;
    in_chan_kind <= s.ck;
    {in_chan, in_begin, in_end, in_seg_type, in_profile, in_len} <=
      {s.chan, s.b, s.e, s.t, s.prof, s.len};
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask

  task automatic raw(input psw_pkg::beat_t k, input logic [31:0] w);
    @(posedge clk);
    lf.valid <= 1'b1;
    lf.kind <= k;
    lf.data <= w;
    do @(posedge clk); while (lf.ready !== 1'b1);
    lf.valid <= 1'b0;
  endtask

  task automatic send_pkt(input logic [2:0] f, input int n);
    seg_t        s [$];
    logic [23:0] c;
    logic [7:0]  by;
    logic        m;
    int          x;
    fl = f;
    for (int i = 0; i < n; i++) begin
      x = seg_no++;
      s.push_back('{x % 3 == 0 ? psw_pkg::CH_SINGLE :
        (x % 3 == 1 ? psw_pkg::CH_OFDM : psw_pkg::CH_LINK),
        x % 3 == 0 ? 8'(16 + $urandom % 4) : (x % 3 == 1 ? ofdm_tag : link_tag),
        1'((x / 3) % 2), 1'($urandom), 1'((x / 6) % 2), 4'($urandom), 14'(8 + $urandom % 5)});
    end
    beat(psw_pkg::BEAT_HDR, '0, 7'(n), 8'h0);
    for (int i = 0; i < n; i++) begin
      notes.push_back(note(psw_pkg::BEAT_ENTRY, 7'(i), s[i], 1'b0, 8'h0));
      beat(psw_pkg::BEAT_ENTRY, s[i], 7'h0, 8'h0);
    end
    for (int i = 0; i < n; i++) begin
      c = psw_pkg::CRC_INIT;
      m = s[i].ck == psw_pkg::CH_LINK && s[i].t;
      for (int j = 0; j < s[i].len; j++) begin
        by = 8'($urandom);
        if (m && j >= s[i].len - 3) notes.push_back(note(psw_pkg::BEAT_PAYLOAD, 7'(i), s[i], 1'b0,
          8'(c >> (8 * (s[i].len - 1 - j)))));
        else notes.push_back(note(psw_pkg::BEAT_PAYLOAD, 7'(i), s[i], m && s[i].b && j < 4, by));
        if (!(m && s[i].b && j < 4) && !(m && j >= s[i].len - 3)) c = crc_step(c, by);
        beat(psw_pkg::BEAT_PAYLOAD, s[i], 7'h0, by);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchers: decoded beats against the notes, loss pulses counted.
  always @(posedge clk) begin
    out_ready <= ($urandom % 4) != 0;
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1)
      check_beat(notes.size() ? notes.pop_front() : 'x,
        {out_kind, out_flow, out_seg, out_len,
        out_msg, out_stamp, out_kind == psw_pkg::BEAT_PAYLOAD ? {8'h0, out_byte} :
        {out_begin, out_end, out_chan_kind, out_profile, out_chan}});
    if (!reset && f_pkt === 1'b1) n_fpkt <= n_fpkt + 8'h1;
    if (!reset && f_seg === 1'b1) n_fseg <= n_fseg + 8'h1;
    if (!reset && (pkt_loss !== 1'b0 || seg_loss !== 1'b0)) n_main <= n_main + 8'h1;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end

  initial begin
    void'($urandom(74));
    {reset, in_valid, in_flow, in_count, in_begin, in_end, in_len} = '0;
    {in_chan, in_profile, in_seg_type, in_byte, out_ready} = '0;
    {lf.valid, lf.data, n_fpkt, n_fseg, n_main} = '0;
    in_kind = psw_pkg::BEAT_HDR;
    in_chan_kind = psw_pkg::CH_SINGLE;
    lf.kind = psw_pkg::BEAT_HDR;
    reset = 1'b1;
    ofdm_tag = 8'h01;
    link_tag = 8'h02;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int p = 0; p < 9; p++) send_pkt(3'(p % 3 == 2 ? 3 : 0), 1 + p % 4);
    for (int p = 0; p < 3; p++) begin
      raw(psw_pkg::BEAT_HDR, {4'h4, 3'h1, 2'h0, 7'h1, 16'(10 + p + p / 2)});
      raw(psw_pkg::BEAT_ENTRY, {2'h3, 14'h1, 8'h05, 4'(p + p / 2), 4'h0});
      raw(psw_pkg::BEAT_PAYLOAD, 32'h0000_00a5);
    end
    for (int i = 0; i < 2000 && notes.size() != 0; i++) @(posedge clk);
    repeat (10) @(posedge clk);
    check_flag(8'h1, n_fpkt);
    check_flag(8'h1, n_fseg);
    check_flag(8'h0, n_main);
    check_flag(8'h0, 8'(notes.size()));
    end_of_test;
  end
endmodule
